//--- rtl/byte_store.sv
// Purpose: 24K byte store for the input buffer
// Assumes: one write and one read port, registered read data
// Notes:   depth fixed
`timescale 1ns/1ps
`include "pport_consts.svh"
module byte_store
(
  input  wire logic               clock,
  input  wire logic               we,
  input  wire logic [`BUF_AW-1:0] waddr,
  input  wire logic [7:0]         wdata,
  input  wire logic [`BUF_AW-1:0] raddr,
  output logic      [7:0]         rdata
);
  logic [7:0] mem [0:`BUF_DEPTH-1];

  // =====================================
  // write and registered read
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : byte_store

//--- rtl/parallel_input_port.sv
// Purpose: receive side of an 8-bit strobe/acknowledge printer port
// Assumes: 100 MHz clock; pins synchronised here; one clock domain
// Notes:   bytes go to a 24K store or straight to a two-entry skid
`timescale 1ns/1ps
`include "pport_consts.svh"
module parallel_input_port
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       strobe_n,
  input  wire logic [7:0] data_lines,
  input  wire logic       init_n,
  input  wire logic       paper_missing,
  input  wire logic       error_in,
  input  wire logic       buffer_24k_sel,
  output logic            byte_received_pulse,
  output logic            busy,
  output logic            no_paper_flag,
  output logic            fault_n,
  output logic [7:0]      out_data,
  output logic            out_valid,
  input  wire logic       out_ready
);
  // =====================================
  // pin synchronisers
  logic [7:0] data_s1, data_s2;
  logic [4:0] pin_s1, pin_s2;
  logic       strobe_s, init_s, pmiss_s, err_s;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
      pin_s1  <= `PIN_SYNC_RST;
      pin_s2  <= `PIN_SYNC_RST;
    end
    else
    begin
      data_s1 <= data_lines;
      data_s2 <= data_s1;
      pin_s1  <= {buffer_24k_sel, error_in, paper_missing, init_n, strobe_n};
      pin_s2  <= pin_s1;
    end
  end
  assign strobe_s = ~pin_s2[`PIN_STB];
  assign init_s   = ~pin_s2[`PIN_INIT];
  assign pmiss_s  = pin_s2[`PIN_PMISS];
  assign err_s    = pin_s2[`PIN_ERR];

  // =====================================
  // buffer size strap after reset release, init low-time qualifier
  logic [1:0]        strap_cnt, next_strap_cnt;
  logic              use_store, next_use_store;
  logic [`CNT_W-1:0] init_cnt, next_init_cnt;
  logic              soft_rst;
  always_comb
  begin
    // strap only trusted once it has crossed both sync stages
    next_strap_cnt = (strap_cnt > 2'(`STRAP_CAP_CYC)) ? strap_cnt : strap_cnt + 2'h1;
    next_use_store = (strap_cnt == 2'(`STRAP_CAP_CYC)) ? pin_s2[`PIN_SEL] : use_store;
    next_init_cnt  = init_s ? ((init_cnt == `CNT_W'(`INIT_MIN_CYC)) ? init_cnt
                               : init_cnt + `CNT_W'(1)) : `CNT_W'(0);
  end
  assign soft_rst = (init_cnt == `CNT_W'(`INIT_MIN_CYC));
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_cnt <= 2'h0;
      use_store <= 1'b0;
      init_cnt  <= '0;
    end
    else
    begin
      strap_cnt <= next_strap_cnt;
      use_store <= next_use_store;
      init_cnt  <= next_init_cnt;
    end
  end

  // =====================================
  // store and skid buffer state
  logic [`BUF_AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [`BUF_AW:0]   fill, next_fill;
  logic               rd_pend, next_rd_pend;
  logic [7:0]         store_q;
  logic [7:0]         skid0, skid1, next_skid0, next_skid1;
  logic [1:0]         skid_n, next_skid_n;
  logic               take, store_we, store_rd, push, pop;
  logic [7:0]         push_data, cap, next_cap;
  logic               store_full, skid_room, zero_hold;

  byte_store i_byte_store
  (
    .clock (clock),
    .we    (store_we),
    .waddr (wptr),
    .wdata (cap),
    .raddr (rptr),
    .rdata (store_q)
  );
  function automatic logic [`BUF_AW-1:0] ptr_inc(input logic [`BUF_AW-1:0] p);
    ptr_inc = (p == `BUF_AW'(`BUF_DEPTH - 1)) ? `BUF_AW'(0) : p + `BUF_AW'(1);
  endfunction : ptr_inc

  // =====================================
  // handshake machine
  pport_pkg::hs_state_t state, next_state;
  logic [`CNT_W-1:0]    cnt, next_cnt;
  logic                 next_ack, next_busy;
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt + `CNT_W'(1);
    next_cap   = cap;
    take       = 1'b0;
    case (state)
      pport_pkg::ST_IDLE:
      begin
        next_cnt = '0;
        if (strobe_s)
          next_state = pport_pkg::ST_QUAL;
      end
      pport_pkg::ST_QUAL:
      begin
        next_cap = data_s2;
        if (!strobe_s)
        begin
          next_cnt = '0;
          // short glitch below minimum width is ignored
          if (cnt >= `CNT_W'(`STROBE_MIN_CYC - 1))
          begin
            take       = 1'b1;
            next_state = pport_pkg::ST_DELAY;
          end
          else
            next_state = pport_pkg::ST_IDLE;
        end
      end
      pport_pkg::ST_DELAY:
      begin
        if (cnt >= `CNT_W'(`ACK_DELAY_CYC - 1))
        begin
          next_cnt   = '0;
          next_state = pport_pkg::ST_ACK;
        end
      end
      default:
      begin
        if (cnt >= `CNT_W'(`ACK_PULSE_CYC - 1))
        begin
          next_cnt   = '0;
          next_state = pport_pkg::ST_IDLE;
        end
      end
    endcase
    if (soft_rst)
    begin
      next_state = pport_pkg::ST_IDLE;
      next_cnt   = '0;
    end
    next_ack  = !(next_state == pport_pkg::ST_ACK);
    // busy through entry, full, error, paper missing, init, zero-buffer hold
    next_busy = (next_state != pport_pkg::ST_IDLE) || store_full || err_s || pmiss_s
                || zero_hold || soft_rst;
  end

  // =====================================
  // buffer next values
  always_comb
  begin
    store_full   = use_store ? (fill >= (`BUF_AW+1)'(`BUF_DEPTH - 1)) : 1'b0;
    zero_hold    = !use_store && (skid_n != 2'd0);
    skid_room    = (skid_n != 2'd2);
    store_we     = take && use_store;
    pop          = out_ready && (skid_n != 2'd0);
    store_rd     = use_store && (fill != '0) && !rd_pend && skid_room && !soft_rst;
    push         = rd_pend || (take && !use_store);
    push_data    = rd_pend ? store_q : cap;
    next_wptr    = store_we ? ptr_inc(wptr) : wptr;
    next_rptr    = store_rd ? ptr_inc(rptr) : rptr;
    next_rd_pend = store_rd;
    next_fill    = fill + {{`BUF_AW{1'b0}}, store_we} - {{`BUF_AW{1'b0}}, store_rd};
    next_skid_n  = skid_n + {1'b0, push} - {1'b0, pop};
    next_skid0   = skid0;
    next_skid1   = skid1;
    if (pop)
      next_skid0 = skid1;
    if (push)
    begin
      if ((skid_n - {1'b0, pop}) == 2'd0)
        next_skid0 = push_data;
      else
        next_skid1 = push_data;
    end
    if (soft_rst)
    begin
      next_wptr    = '0;
      next_rptr    = '0;
      next_fill    = '0;
      next_rd_pend = 1'b0;
      next_skid_n  = 2'd0;
    end
  end

  // =====================================
  // registers
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state               <= pport_pkg::ST_IDLE;
      cnt                 <= '0;
      cap                 <= 8'h00;
      byte_received_pulse <= 1'b1;
      busy                <= 1'b1;
      no_paper_flag       <= 1'b0;
      fault_n             <= 1'b1;
      wptr                <= '0;
      rptr                <= '0;
      fill                <= '0;
      rd_pend             <= 1'b0;
      skid0               <= 8'h00;
      skid1               <= 8'h00;
      skid_n              <= 2'd0;
      out_data            <= 8'h00;
      out_valid           <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      cnt                 <= next_cnt;
      cap                 <= next_cap;
      byte_received_pulse <= next_ack;
      busy                <= next_busy;
      no_paper_flag       <= pmiss_s;
      fault_n             <= !(pmiss_s || err_s);
      wptr                <= next_wptr;
      rptr                <= next_rptr;
      fill                <= next_fill;
      rd_pend             <= next_rd_pend;
      skid0               <= next_skid0;
      skid1               <= next_skid1;
      skid_n              <= next_skid_n;
      out_data            <= next_skid0;
      out_valid           <= (next_skid_n != 2'd0);
    end
  end

  // =====================================
  // checks
  a_ack_after_entry: assert property (@(posedge clock) disable iff (sys_rst)
    (state == pport_pkg::ST_DELAY) && (next_state == pport_pkg::ST_ACK) |=> !byte_received_pulse)
    else $error("ack pulse missing");
  a_busy_in_ack: assert property (@(posedge clock) disable iff (sys_rst)
    !byte_received_pulse |-> busy)
    else $error("busy low during ack");
  a_fault_on_paper: assert property (@(posedge clock) disable iff (sys_rst)
    pmiss_s |=> !fault_n && no_paper_flag)
    else $error("fault or paper flag wrong");
  a_busy_on_error: assert property (@(posedge clock) disable iff (sys_rst)
    err_s |=> busy)
    else $error("busy low in error");
  a_init_clears: assert property (@(posedge clock) disable iff (sys_rst)
    soft_rst |=> (fill == '0) && (skid_n == 2'd0))
    else $error("init did not clear buffer");
  a_zero_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !use_store && (skid_n != 2'd0) |=> busy)
    else $error("busy low with unconsumed byte");
  a_short_strobe: assert property (@(posedge clock) disable iff (sys_rst)
    (state == pport_pkg::ST_QUAL) && !strobe_s && (cnt < `CNT_W'(`STROBE_MIN_CYC - 1))
    |-> !take)
    else $error("short strobe accepted");
  a_busy_idle_low: assert property (@(posedge clock) disable iff (sys_rst)
    (state == pport_pkg::ST_IDLE) && !store_full && !err_s && !pmiss_s && !zero_hold
    && !soft_rst && !strobe_s |=> !busy)
    else $error("busy high while able");
  c_take: cover property (@(posedge clock) take);
  c_ack: cover property (@(posedge clock) $fell(byte_received_pulse));
  c_skid_full: cover property (@(posedge clock) skid_n == 2'd2);
  c_init: cover property (@(posedge clock) soft_rst);
endmodule : parallel_input_port

//--- rtl/pport_consts.svh
// Purpose: named constants for the parallel input port
// Assumes: 100 MHz clock
// Notes:   times kept in ns, cycle counts derived
`ifndef PPORT_CONSTS_SVH
`define PPORT_CONSTS_SVH
`define CLK_PERIOD_NS     10
`define STROBE_MIN_NS     500
`define STROBE_MIN_CYC    ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_PULSE_NS      12000
`define ACK_PULSE_CYC     (`ACK_PULSE_NS / `CLK_PERIOD_NS)
`define INIT_MIN_NS       50000
`define INIT_MIN_CYC      ((`INIT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_DELAY_NS      5000
`define ACK_DELAY_CYC     (`ACK_DELAY_NS / `CLK_PERIOD_NS)
`define BUF_AW            15
`define BUF_DEPTH         24576
`define CNT_W             16
`define STRAP_CAP_CYC     2      // strap read once past both sync stages
`define PIN_SYNC_RST      5'h03  // idle levels: strobe and init high
`define PIN_STB           0
`define PIN_INIT          1
`define PIN_PMISS         2
`define PIN_ERR           3
`define PIN_SEL           4
`endif

//--- rtl/pport_pkg.sv
// Purpose: types for the parallel input port
// Assumes: nothing
// Notes:   states of the handshake machine
package pport_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_QUAL  = 2'b01,
    ST_DELAY = 2'b10,
    ST_ACK   = 2'b11
  } hs_state_t;
endpackage : pport_pkg

//--- sim/host_model.sv
// Purpose: host side of the strobe and acknowledge printer port
// Assumes: drives only at the falling edge of clock
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ps
module host_model
(
  input  wire logic       clock,
  input  wire logic       busy,
  input  wire logic       byte_received_pulse,
  output logic            strobe_n,
  output logic [7:0]      data_lines
);
  // ==========================================
  // transfer
  initial
  begin
    strobe_n   = 1'b1;
    data_lines = 8'h00;
  end

  // one strobe transfer, width in clock cycles
  // late marks a busy wait that ran out before busy fell
  task automatic send(input logic [7:0] b, input int width, output logic late);
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 5000)
    begin
      @(negedge clock);
      t++;
    end
    late       = (t >= 5000);
    data_lines = b;
    @(negedge clock);
    strobe_n = 1'b0;
    repeat (width) @(negedge clock);
    strobe_n = 1'b1;
    repeat (6) @(negedge clock);
    data_lines = ~b; // released lines stop showing the byte
  endtask : send
endmodule : host_model

//--- sim/parallel_input_port_tb.sv
// Purpose: self-checking bench for the parallel input port
// Assumes: 100 MHz clock; host model drives strobe and data
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
`include "pport_consts.svh"
module parallel_input_port_tb;
  logic       clock          = 1'b0;
  logic       sys_rst        = 1'b1;
  logic       init_n         = 1'b1;
  logic       paper_missing  = 1'b0;
  logic       error_in       = 1'b0;
  logic       buffer_24k_sel = 1'b1;
  logic       out_ready      = 1'b1;
  logic       strobe_n;
  logic [7:0] data_lines;
  logic       byte_received_pulse;
  logic       busy;
  logic       no_paper_flag;
  logic       fault_n;
  logic       out_valid;
  logic [7:0] out_data;
  logic [7:0] rxq[$];
  int         err_count      = 0;
  int         checks         = 0;

  // ==========================================
  // clock, design, host
  always #5 clock = ~clock;

  parallel_input_port i_parallel_input_port
  (
    .clock(clock), .sys_rst(sys_rst), .strobe_n(strobe_n), .data_lines(data_lines),
    .init_n(init_n), .paper_missing(paper_missing), .error_in(error_in),
    .buffer_24k_sel(buffer_24k_sel), .byte_received_pulse(byte_received_pulse),
    .busy(busy), .no_paper_flag(no_paper_flag), .fault_n(fault_n),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready)
  );

  host_model i_host_model
  (
    .clock(clock), .busy(busy), .byte_received_pulse(byte_received_pulse),
    .strobe_n(strobe_n), .data_lines(data_lines)
  );

  // bytes taken by the printing side
  always @(posedge clock)
    if (out_valid === 1'b1 && out_ready === 1'b1)
      rxq.push_back(out_data);

  // ==========================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic sel);
    buffer_24k_sel = sel;
    sys_rst        = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (8) @(negedge clock);
  endtask : do_reset

  // full transfer; checks busy and the acknowledge pulse
  task automatic xfer(input logic [7:0] b);
    int t;
    int n;
    logic hi;
    logic late;
    t  = 0;
    n  = 0;
    hi = 1'b1;
    i_host_model.send(b, 60, late);
    check(16'(late), 16'h0000);
    check(16'(busy), 16'h0001);
    while (byte_received_pulse !== 1'b0 && t < 2000)
    begin
      @(negedge clock);
      t++;
    end
    while (byte_received_pulse === 1'b0 && n < 3000)
    begin
      hi = hi & (busy === 1'b1);
      @(negedge clock);
      n++;
    end
    check(16'(n), 16'(`ACK_PULSE_CYC));
    check(16'(hi), 16'h0001);
    repeat (5) @(negedge clock);
  endtask : xfer

  task automatic pop(input logic [7:0] exp);
    check(16'(rxq.size() > 0), 16'h0001);
    if (rxq.size() > 0)
      check(16'(rxq.pop_front()), 16'(exp));
  endtask : pop

  // ==========================================
  // scenarios
  task automatic s_walk;
    for (int i = 0; i < 8; i++)
    begin
      xfer(8'h01 << i);
      check(16'(busy), 16'h0000);
      pop(8'h01 << i);
    end
  endtask : s_walk

  task automatic s_short;
    logic late;
    i_host_model.send(8'h3c, 20, late);
    check(16'(late), 16'h0000);
    repeat (700) @(negedge clock);
    check(16'({busy, byte_received_pulse}), 16'h0001);
    check(16'(rxq.size()), 16'h0000);
  endtask : s_short

  task automatic s_stall;
    out_ready = 1'b0;
    xfer(8'h11);
    xfer(8'h22);
    // third byte waits in the store while the skid is full
    xfer(8'h33);
    check(16'(busy), 16'h0000);
    out_ready = 1'b1;
    repeat (10) @(negedge clock);
    pop(8'h11);
    pop(8'h22);
    pop(8'h33);
  endtask : s_stall

  task automatic s_zero;
    do_reset(1'b0);
    out_ready = 1'b0;
    xfer(8'h5a);
    repeat (20) @(negedge clock);
    check(16'({busy, out_valid, out_data}), 16'h035a);
    out_ready = 1'b1;
    repeat (10) @(negedge clock);
    check(16'(busy), 16'h0000);
    pop(8'h5a);
  endtask : s_zero

  task automatic s_status;
    error_in = 1'b1;
    repeat (10) @(negedge clock);
    check(16'({busy, fault_n, no_paper_flag}), 16'h0004);
    error_in      = 1'b0;
    paper_missing = 1'b1;
    repeat (10) @(negedge clock);
    check(16'({busy, fault_n, no_paper_flag}), 16'h0005);
    paper_missing = 1'b0;
    repeat (10) @(negedge clock);
    check(16'({busy, fault_n, no_paper_flag}), 16'h0002);
  endtask : s_status

  task automatic s_init;
    do_reset(1'b1);
    out_ready = 1'b0;
    xfer(8'h77);
    init_n = 1'b0;
    repeat (100) @(negedge clock);
    init_n = 1'b1;
    repeat (10) @(negedge clock);
    check(16'(out_valid), 16'h0001);
    init_n = 1'b0;
    repeat (`INIT_MIN_CYC + 20) @(negedge clock);
    check(16'(busy), 16'h0001);
    init_n = 1'b1;
    repeat (20) @(negedge clock);
    check(16'(out_valid), 16'h0000);
    out_ready = 1'b1;
    repeat (10) @(negedge clock);
    check(16'(rxq.size()), 16'h0000);
  endtask : s_init

  // ==========================================
  // run control
  task end_sim;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    // scenarios need about 30k cycles; allow twice that
    #600000;
    err_count++;
    end_sim();
  end

  initial
  begin
    do_reset(1'b1);
    check(16'({byte_received_pulse, busy, fault_n}), 16'h0005);
    s_walk();
    s_short();
    s_stall();
    s_status();
    s_zero();
    s_init();
    end_sim();
  end
endmodule : parallel_input_port_tb
